/* verilog/gpib_regs.svh */
// Purpose: Named constants for the bus address and remote/local block
// Assumes: Seven-bit message codes, DIO8 ignored when decoding
// Notes: Definitions only
`ifndef GPIB_REGS_SVH
`define GPIB_REGS_SVH

`define CMD_GO_LOCAL 7'h01
`define CMD_SEL_CLEAR 7'h04
`define CMD_PP_CONFIG 7'h05
`define CMD_TRIGGER 7'h08
`define CMD_TAKE_CTRL 7'h09
`define CMD_LOCKOUT 7'h11
`define CMD_DEV_CLEAR 7'h14
`define CMD_PP_UNCONFIG 7'h15
`define CMD_SPOLL_EN 7'h18
`define CMD_SPOLL_DIS 7'h19
`define CHAR_LOCAL 7'h4C
`define ADDR_NONE 5'h1F
`define CODE_HI 6
`define GRP_HI 6
`define GRP_LO 5
`define UCG_BIT 4
`define ADDR_HI 4
`define GRP_CMD 2'h0
`define GRP_LISTEN 2'h1
`define GRP_TALK 2'h2
`define GRP_SECOND 2'h3
`define DIO_W 8
`define ADDR_W 5
`define PANEL_W 8
`define SYNC_W 25
`define CAPTURE_WAIT 2'h2

`endif

/* verilog/gpib_pkg.sv */
// Purpose: Types shared by the bus address and remote/local block
// Assumes: Nothing beyond the constants header
// Notes: Enumerations only
package gpib_pkg;
    typedef enum logic [2:0] {
        grp_addressed,
        grp_universal,
        grp_listen,
        grp_talk,
        grp_secondary
    } msg_group_t;

    typedef enum logic [1:0] {
        acc_idle,
        acc_ready,
        acc_hold,
        acc_done
    } acceptor_state_t;
endpackage

/* verilog/gpib_side_if.sv */
// Purpose: Carries synchronised bus levels and received bytes between modules
// Assumes: All signals on sys_clk, true polarity
// Notes: Three parties: synchroniser, acceptor, decoder
`timescale 1ns/1ps
`default_nettype none
`include "gpib_regs.svh"
interface gpib_side_if;
    logic [`DIO_W-1:0] dio;
    logic atn;
    logic ren;
    logic dav;
    logic ifc;
    logic [`ADDR_W-1:0] sw_addr;
    logic [`PANEL_W-1:0] panel;
    logic active;
    logic rx_strobe;
    logic [`DIO_W-1:0] rx_byte;
    logic rx_atn;

    modport sync_mp (output dio, atn, ren, dav, ifc, sw_addr, panel);
    modport acc_mp (input dio, atn, dav, active, output rx_strobe, rx_byte, rx_atn);
    modport core_mp (input atn, ren, ifc, sw_addr, panel, rx_strobe, rx_byte, rx_atn, output active);
endinterface
`default_nettype wire

/* verilog/gpib_input_sync.sv */
// Purpose: Two-stage synchroniser for every pin input, with polarity fix
// Assumes: Bus lines are low-true, switches and panel are high-true
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
`include "gpib_regs.svh"
module gpib_input_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`DIO_W-1:0] dio_n,
    input wire logic atn_n,
    input wire logic ren_n,
    input wire logic dav_n,
    input wire logic ifc_n,
    input wire logic [`ADDR_W-1:0] addr_sw,
    input wire logic [`PANEL_W-1:0] panel_in,
    gpib_side_if.sync_mp side
);
    logic [`SYNC_W-1:0] meta;
    logic [`SYNC_W-1:0] stable;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            stable <= '0;
        end else if (clk_en) begin
            meta <= {~dio_n, ~atn_n, ~ren_n, ~dav_n, ~ifc_n, addr_sw, panel_in};
            stable <= meta;
        end
    end

    // Low level on a bus line means asserted
    assign {side.dio, side.atn, side.ren, side.dav, side.ifc, side.sw_addr, side.panel} = stable;
endmodule
`default_nettype wire

/* verilog/gpib_acceptor.sv */
// Purpose: Listener side of the three-wire byte handshake
// Assumes: DIO settles before DAV on the bus, both pass equal synchronisers
// Notes: Open-drain lines: oe high pulls the line low (asserted)
`timescale 1ns/1ps
`default_nettype none
`include "gpib_regs.svh"
module gpib_acceptor
    import gpib_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    gpib_side_if.acc_mp side,
    output logic nrfd_n_out,
    output logic nrfd_oe,
    output logic ndac_n_out,
    output logic ndac_oe
);
    acceptor_state_t state;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= acc_idle;
        end else if (clk_en) begin
            if (!side.active) begin
                state <= acc_idle;
            end else begin
                unique case (state)
                    acc_idle: state <= acc_ready;
                    acc_ready: if (side.dav) state <= acc_hold;
                    acc_hold: state <= acc_done;
                    acc_done: if (!side.dav) state <= acc_ready;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            side.rx_strobe <= 1'b0;
            side.rx_byte <= '0;
            side.rx_atn <= 1'b0;
        end else if (clk_en) begin
            side.rx_strobe <= side.active && state == acc_ready && side.dav;
            if (side.active && state == acc_ready && side.dav) begin
                side.rx_byte <= side.dio;
                side.rx_atn <= side.atn;
            end
        end
    end

    // Not ready from byte taken until DAV drops; not accepted until the byte is taken
    assign nrfd_oe = state == acc_hold || state == acc_done;
    assign ndac_oe = state == acc_ready || state == acc_hold;
    assign nrfd_n_out = 1'b0;
    assign ndac_n_out = 1'b0;

    a_byte_taken: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && side.active && state == acc_ready && side.dav) |=> (nrfd_oe && ndac_oe && side.rx_strobe))
        else $error("byte not taken or handshake lines not held");
endmodule
`default_nettype wire

/* verilog/ieee488_address_remote_local.sv */
// Purpose: Instrument-side bus message decoding, addressing and remote/local control
// Assumes: Listener only; talker output, SRQ and command parsing live elsewhere
// Notes: Address switches are read once after reset release
//
// Overview of operation
// - ATN bytes are interface messages, others device-dependent
// - Addressed commands act only when addressed
// - Universal commands act regardless of addressing
// - Listen/talk address decode, 31 means unlisten/untalk
// - Secondary group bytes are ignored
// - Address from five binary-weighted switches
// - Switch value captured at power-up only
// - Power-up enters local, indicator off
// - Local state discards device-dependent bytes
// - Go-to-local, power-up or 'L' return local
// - Remote lights indicator, blocks panel controls
// - Own listen address with REN enters remote
// - Bus lines are low-true
// - Listener holds NDAC until byte taken, NRFD from then until DAV drops
`timescale 1ns/1ps
`default_nettype none
`include "gpib_regs.svh"
module ieee488_address_remote_local
    import gpib_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`DIO_W-1:0] dio_n,
    input wire logic atn_n,
    input wire logic ren_n,
    input wire logic dav_n,
    input wire logic ifc_n,
    output logic nrfd_n_out,
    output logic nrfd_oe,
    output logic ndac_n_out,
    output logic ndac_oe,
    input wire logic [`ADDR_W-1:0] addr_sw,
    input wire logic [`PANEL_W-1:0] panel_in,
    output logic [`PANEL_W-1:0] panel_out,
    output logic remote_led,
    output logic [`ADDR_W-1:0] own_addr,
    output logic listen,
    output logic talk,
    output logic lockout,
    output logic spoll_enabled,
    output logic clear_pulse,
    output logic trigger_pulse,
    output logic take_ctrl_pulse,
    output logic pp_config_pulse,
    output logic pp_unconfig_pulse,
    output logic dd_valid,
    output logic [`DIO_W-1:0] dd_byte
);
    logic rst_meta;
    logic rst_sync_n;
    logic addr_ok;
    logic [1:0] capture_wait;
    logic remote;
    msg_group_t grp;
    logic [`CODE_HI:0] code;
    logic is_cmd;
    logic is_data;
    logic own_listen;
    logic own_talk;

    gpib_side_if side ();

    function automatic msg_group_t classify(input logic [`CODE_HI:0] c);
        if (c[`GRP_HI:`GRP_LO] == `GRP_CMD) begin
            classify = c[`UCG_BIT] ? grp_universal : grp_addressed;
        end else if (c[`GRP_HI:`GRP_LO] == `GRP_LISTEN) begin
            classify = grp_listen;
        end else if (c[`GRP_HI:`GRP_LO] == `GRP_TALK) begin
            classify = grp_talk;
        end else begin
            classify = grp_secondary;
        end
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    gpib_input_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .clk_en(clk_en),
        .dio_n(dio_n),
        .atn_n(atn_n),
        .ren_n(ren_n),
        .dav_n(dav_n),
        .ifc_n(ifc_n),
        .addr_sw(addr_sw),
        .panel_in(panel_in),
        .side(side.sync_mp)
    );

    gpib_acceptor u_acc (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .clk_en(clk_en),
        .side(side.acc_mp),
        .nrfd_n_out(nrfd_n_out),
        .nrfd_oe(nrfd_oe),
        .ndac_n_out(ndac_n_out),
        .ndac_oe(ndac_oe)
    );

    // Every device handshakes command bytes; data bytes only when listening
    assign side.active = side.atn || listen;

    assign code = side.rx_byte[`CODE_HI:0];
    assign grp = classify(code);
    assign is_cmd = side.rx_strobe && side.rx_atn;
    assign is_data = side.rx_strobe && !side.rx_atn;
    assign own_listen = is_cmd && grp == grp_listen && code[`ADDR_HI:0] == own_addr && addr_ok;
    assign own_talk = is_cmd && grp == grp_talk && code[`ADDR_HI:0] == own_addr && addr_ok;

    // Switch weights 1..16 map straight onto the address bits once synchronised
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            capture_wait <= '0;
            addr_ok <= 1'b0;
            own_addr <= '0;
        end else if (clk_en && !addr_ok) begin
            if (capture_wait == `CAPTURE_WAIT) begin
                own_addr <= side.sw_addr;
                addr_ok <= 1'b1;
            end else begin
                capture_wait <= capture_wait + 2'h1;
            end
        end
    end

    // Listen and talk addressing; secondary bytes fall through untouched
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            listen <= 1'b0;
            talk <= 1'b0;
        end else if (clk_en) begin
            if (side.ifc) begin
                listen <= 1'b0;
                talk <= 1'b0;
            end else if (is_cmd && grp == grp_listen) begin
                if (own_listen) begin
                    listen <= 1'b1;
                end else if (code[`ADDR_HI:0] == `ADDR_NONE) begin
                    listen <= 1'b0;
                end
            end else if (is_cmd && grp == grp_talk) begin
                talk <= own_talk;
            end
        end
    end

    // Remote/local state
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            remote <= 1'b0;
        end else if (clk_en) begin
            if (own_listen && side.ren) begin
                remote <= 1'b1;
            end else if (is_cmd && grp == grp_addressed && code == `CMD_GO_LOCAL && listen) begin
                remote <= 1'b0;
            end else if (is_data && listen && code == `CHAR_LOCAL) begin
                remote <= 1'b0;
            end
        end
    end

    // Front panel gating and indicator
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_out <= '0;
            remote_led <= 1'b0;
        end else if (clk_en) begin
            panel_out <= remote ? '0 : side.panel;
            remote_led <= remote;
        end
    end

    // Interface message actions
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clear_pulse <= 1'b0;
            trigger_pulse <= 1'b0;
            take_ctrl_pulse <= 1'b0;
            pp_config_pulse <= 1'b0;
            pp_unconfig_pulse <= 1'b0;
        end else if (clk_en) begin
            clear_pulse <= is_cmd && ((code == `CMD_SEL_CLEAR && listen) || code == `CMD_DEV_CLEAR);
            trigger_pulse <= is_cmd && code == `CMD_TRIGGER && listen;
            take_ctrl_pulse <= is_cmd && code == `CMD_TAKE_CTRL && talk;
            pp_config_pulse <= is_cmd && code == `CMD_PP_CONFIG && listen;
            pp_unconfig_pulse <= is_cmd && code == `CMD_PP_UNCONFIG;
        end
    end

    // Lockout set by LLO, cleared when REN drops or on IFC; serial poll mode is set and cleared by universal commands
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lockout <= 1'b0;
            spoll_enabled <= 1'b0;
        end else if (clk_en) begin
            if (!side.ren || side.ifc) begin
                lockout <= 1'b0;
            end else if (is_cmd && code == `CMD_LOCKOUT) begin
                lockout <= 1'b1;
            end
            if (side.ifc || (is_cmd && code == `CMD_SPOLL_DIS)) begin
                spoll_enabled <= 1'b0;
            end else if (is_cmd && code == `CMD_SPOLL_EN) begin
                spoll_enabled <= 1'b1;
            end
        end
    end

    // Device-dependent bytes go out only in remote; the local character is consumed
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dd_valid <= 1'b0;
            dd_byte <= '0;
        end else if (clk_en) begin
            dd_valid <= is_data && listen && remote && code != `CHAR_LOCAL;
            if (is_data && listen && remote) begin
                dd_byte <= side.rx_byte;
            end
        end
    end

    a_remote_cause: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        $rose(remote) |-> $past(own_listen && side.ren))
        else $error("remote entered without own listen address and REN");

    a_gtl_local: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && code == `CMD_GO_LOCAL && listen) |=> !remote)
        else $error("go-to-local while listening did not return to local");

    a_char_local: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_data && listen && code == `CHAR_LOCAL) |=> !remote ##1 !remote_led)
        else $error("local character did not return to local");

    a_local_discard: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_data && !remote) |=> !dd_valid)
        else $error("device-dependent byte passed in local state");

    a_sdc_addressed: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && code == `CMD_SEL_CLEAR) |=> (clear_pulse == $past(listen)))
        else $error("selected clear not gated by addressing");

    a_dcl_universal: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && code == `CMD_DEV_CLEAR) |=> clear_pulse)
        else $error("device clear ignored");

    a_secondary_ignored: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && grp == grp_secondary && !side.ifc) |=>
        ($stable(remote) && $stable(listen) && $stable(talk) && !clear_pulse && !trigger_pulse))
        else $error("secondary byte changed state");

    a_panel_blocked: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && remote) |=> (panel_out == '0 && remote_led))
        else $error("panel not blocked in remote");

    a_addr_frozen: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        addr_ok |=> $stable(own_addr) && addr_ok)
        else $error("address changed after capture");

    a_unlisten: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && grp == grp_listen && code[`ADDR_HI:0] == `ADDR_NONE && !own_listen) |=> !listen)
        else $error("unlisten did not clear listen");

    a_listen_own: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && own_listen && !side.ifc) |=> listen)
        else $error("own listen address did not set listen");

    a_talk_own: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && grp == grp_talk && !side.ifc) |=> (talk == $past(own_talk)))
        else $error("talk address did not set or clear talk");

    a_trigger_gated: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && code == `CMD_TRIGGER) |=> (trigger_pulse == $past(listen)))
        else $error("trigger not gated by addressing");

    a_ppu_universal: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_cmd && code == `CMD_PP_UNCONFIG) |=> pp_unconfig_pulse)
        else $error("parallel poll unconfigure ignored");

    a_dd_forward: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (clk_en && is_data && listen && remote && code != `CHAR_LOCAL) |=> (dd_valid && dd_byte == $past(side.rx_byte)))
        else $error("device-dependent byte not forwarded in remote");

    c_enter_remote: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) $rose(remote));
    c_dd_byte: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) dd_valid);
    c_remote_local: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) $fell(remote));
    c_trigger: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) trigger_pulse);
endmodule
`default_nettype wire

/* dv/gpib_controller_model.sv */
// Purpose: Behavioural bus controller that sources one byte per handshake
// Assumes: Handshake lines are wired with pull-ups, data lines float high
// Notes: Any bounded wait that runs out raises stuck
`timescale 1ns/1ps
`default_nettype none
module gpib_controller_model (
    input wire logic sys_clk,
    input wire logic nrfd_n,
    input wire logic ndac_n,
    output logic [7:0] dio_n,
    output logic atn_n,
    output logic ren_n,
    output logic dav_n,
    output logic ifc_n,
    output logic stuck
);
    initial begin
        dio_n = 8'hFF;
        atn_n = 1'b1;
        ren_n = 1'b1;
        dav_n = 1'b1;
        ifc_n = 1'b1;
        stuck = 1'b0;
    end

    // Waits for a handshake line to read high (false), within 40 cycles
    task automatic wait_high(input bit use_ndac);
        int n;
        for (n = 0; n < 40 && (use_ndac ? ndac_n : nrfd_n) !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        if ((use_ndac ? ndac_n : nrfd_n) !== 1'b1) begin
            stuck <= 1'b1;
        end
    endtask

    task automatic set_ren(input logic on);
        @(posedge sys_clk);
        ren_n <= ~on;
    endtask

    // Bus clear: IFC low for three cycles
    task automatic pulse_ifc();
        @(posedge sys_clk);
        ifc_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ifc_n <= 1'b1;
    endtask

    task automatic send(input logic [7:0] b, input logic atn);
        @(posedge sys_clk);
        atn_n <= ~atn;
        repeat (4) @(posedge sys_clk);
        wait_high(1'b0);
        dio_n <= ~b;
        @(posedge sys_clk);
        dav_n <= 1'b0;
        @(posedge sys_clk);
        wait_high(1'b1);
        dav_n <= 1'b1;
        dio_n <= 8'hFF;
    endtask
endmodule
`default_nettype wire

/* dv/ieee488_address_remote_local_test.sv */
// Purpose: Self-checking bench for addressing and remote/local control
// Assumes: Controller model on the bus, one clock at 40 MHz
// Notes: Pulse outputs are counted every cycle and compared as totals
`timescale 1ns/1ps
`default_nettype none
`include "gpib_regs.svh"
module ieee488_address_remote_local_test;
    logic sys_clk, rst_n, clk_en, atn_n, ren_n, dav_n, ifc_n, stuck;
    logic [`DIO_W-1:0] dio_n, dd_byte, d;
    logic nrfd_n_out, nrfd_oe, ndac_n_out, ndac_oe, nrfd_line, ndac_line;
    logic [`ADDR_W-1:0] addr_sw, own_addr, addr, other;
    logic [`PANEL_W-1:0] panel_in, panel_out;
    logic remote_led, listen, talk, lockout, spoll_enabled, clear_pulse, trigger_pulse;
    logic take_ctrl_pulse, pp_config_pulse, pp_unconfig_pulse, dd_valid;
    int mismatches, n_checks, n_clr, n_trg, n_tct, n_ppc, n_ppu, n_dd, k;
    logic [7:0] acg [4];

    ieee488_address_remote_local ieee488_address_remote_local_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_en(clk_en), .dio_n(dio_n), .atn_n(atn_n), .ren_n(ren_n), .dav_n(dav_n), .ifc_n(ifc_n),
        .nrfd_n_out(nrfd_n_out), .nrfd_oe(nrfd_oe), .ndac_n_out(ndac_n_out), .ndac_oe(ndac_oe),
        .addr_sw(addr_sw), .panel_in(panel_in), .panel_out(panel_out), .remote_led(remote_led),
        .own_addr(own_addr), .listen(listen), .talk(talk), .lockout(lockout),
        .spoll_enabled(spoll_enabled), .clear_pulse(clear_pulse), .trigger_pulse(trigger_pulse),
        .take_ctrl_pulse(take_ctrl_pulse), .pp_config_pulse(pp_config_pulse),
        .pp_unconfig_pulse(pp_unconfig_pulse), .dd_valid(dd_valid), .dd_byte(dd_byte));

    gpib_controller_model gpib_controller_model_i (.sys_clk(sys_clk), .nrfd_n(nrfd_line),
        .ndac_n(ndac_line), .dio_n(dio_n), .atn_n(atn_n), .ren_n(ren_n), .dav_n(dav_n),
        .ifc_n(ifc_n), .stuck(stuck));

    // Open-drain lines with pull-ups
    assign nrfd_line = nrfd_oe ? nrfd_n_out : 1'b1;
    assign ndac_line = ndac_oe ? ndac_n_out : 1'b1;

    always #12.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (clear_pulse === 1'b1) n_clr++;
        if (trigger_pulse === 1'b1) n_trg++;
        if (take_ctrl_pulse === 1'b1) n_tct++;
        if (pp_config_pulse === 1'b1) n_ppc++;
        if (pp_unconfig_pulse === 1'b1) n_ppu++;
        if (dd_valid === 1'b1) n_dd++;
    end

    function automatic logic [7:0] lad(input logic [4:0] a);
        return 8'h20 | {3'h0, a};
    endfunction

    function automatic logic [7:0] tad(input logic [4:0] a);
        return 8'h40 | {3'h0, a};
    endfunction

    // Printable data byte that is never the return-to-local character
    function automatic logic [7:0] rand_data();
        logic [7:0] v;
        v = 8'h4C;
        while (v == 8'h4C) v = 8'($urandom_range(8'h7E, 8'h20));
        return v;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] b, input logic atn);
        gpib_controller_model_i.send(b, atn);
        repeat (5) @(posedge sys_clk);
        if (stuck === 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic power_up(input logic [4:0] a);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        addr_sw <= a;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        acg = '{8'h01, 8'h04, 8'h05, 8'h08};
        void'($urandom(32'h4f6a));
        addr = 5'($urandom_range(30, 1));
        other = (addr == 5'h1E) ? 5'h01 : addr + 5'h01;
        addr_sw = addr;
        panel_in = 8'($urandom);
        power_up(addr);
        chk(8'(own_addr), 8'(addr));
        chk(8'(remote_led), 8'h00);
        chk(panel_out, panel_in);
        addr_sw <= ~addr;
        repeat (8) @(posedge sys_clk);
        chk(8'(own_addr), 8'(addr));
        d = rand_data();
        cmd(d, 1'b0);
        chk(8'(n_dd), 8'h00);
        chk(8'({nrfd_line, ndac_line}), 8'h03);
        cmd(lad(addr), 1'b1);
        chk(8'(listen), 8'h01);
        chk(8'({nrfd_line, ndac_line}), 8'h02);
        chk(8'(remote_led), 8'h00);
        cmd(d, 1'b0);
        chk(8'(n_dd), 8'h00);
        gpib_controller_model_i.set_ren(1'b1);
        cmd(lad(other), 1'b1);
        chk(8'(remote_led), 8'h00);
        cmd(lad(addr), 1'b1);
        chk(8'(remote_led), 8'h01);
        panel_in <= 8'($urandom) | 8'h01;
        repeat (4) @(posedge sys_clk);
        chk(panel_out, 8'h00);
        for (k = 1; k <= 4; k++) begin
            d = rand_data();
            cmd(d, 1'b0);
            chk(8'(n_dd), 8'(k));
            chk(dd_byte, d);
        end
        cmd(8'h60 | {3'h0, addr}, 1'b1);
        chk(8'(talk), 8'h00);
        chk(8'(listen), 8'h01);
        cmd(8'h09, 1'b1);
        chk(8'(n_tct), 8'h00);
        for (k = 1; k < 4; k++) cmd(acg[k], 1'b1);
        chk(8'({n_clr[3:0], n_ppc[1:0], n_trg[1:0]}), 8'h15);
        cmd(tad(addr), 1'b1);
        chk(8'(talk), 8'h01);
        cmd(8'h09, 1'b1);
        chk(8'(n_tct), 8'h01);
        cmd(8'h5F, 1'b1);
        chk(8'(talk), 8'h00);
        cmd(8'h3F, 1'b1);
        chk(8'(listen), 8'h00);
        for (k = 0; k < 4; k++) cmd(acg[k], 1'b1);
        chk(8'({n_clr[3:0], n_ppc[1:0], n_trg[1:0]}), 8'h15);
        chk(8'(remote_led), 8'h01);
        cmd(8'h11, 1'b1);
        chk(8'(lockout), 8'h01);
        cmd(8'h14, 1'b1);
        cmd(8'h15, 1'b1);
        chk(8'({n_clr[3:0], n_ppu[3:0]}), 8'h21);
        cmd(8'h18, 1'b1);
        chk(8'(spoll_enabled), 8'h01);
        gpib_controller_model_i.pulse_ifc();
        repeat (5) @(posedge sys_clk);
        chk(8'({lockout, spoll_enabled}), 8'h00);
        cmd(8'h19, 1'b1);
        chk(8'(spoll_enabled), 8'h00);
        cmd(lad(addr), 1'b1);
        cmd(8'h01, 1'b1);
        chk(8'(remote_led), 8'h00);
        chk(panel_out, panel_in);
        cmd(lad(addr), 1'b1);
        chk(8'(remote_led), 8'h01);
        cmd(8'h4C, 1'b0);
        chk(8'(remote_led), 8'h00);
        chk(8'(n_dd), 8'h04);
        addr = other;
        power_up(addr);
        chk(8'(own_addr), 8'(addr));
        chk(8'({remote_led, listen, talk}), 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
